// File: hdl/rx_char_shifter.v
`timescale 1ns/1ps
module rx_char_shifter (
  input wire mclk,
  input wire rstn,
  input wire tick16,
  input wire rxd,
  input wire abort,
  input wire [1:0] nbits,
  input wire ad_en,
  output reg done,
  output reg [7:0] data,
  output reg ad,
  output reg ferr,
  output reg brk
);
`include "uart_rx_wake_regs.vh"
localparam S_WAIT = 3'h0;
localparam S_HUNT = 3'h1;
localparam S_START = 3'h2;
localparam S_DATA = 3'h3;
localparam S_STOP = 3'h4;
reg [2:0] st_r;
reg [3:0] cnt_r;
reg [3:0] idx_r;
reg [8:0] sh_r;
wire [3:0] total = {2'h0, nbits} + 4'h5 + {3'h0, ad_en};
wire [8:0] full = sh_r >> (4'h9 - total);
wire [7:0] dmask = 8'hFF >> (2'h3 - nbits);
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    st_r <= S_WAIT;
    cnt_r <= 4'h0;
    idx_r <= 4'h0;
    sh_r <= 9'h000;
    done <= 1'b0;
    data <= 8'h00;
    ad <= 1'b0;
    ferr <= 1'b0;
    brk <= 1'b0;
  end else begin
    done <= 1'b0;
    if (abort) begin
      st_r <= S_WAIT;
    end else begin
      case (st_r)
        S_WAIT: if (rxd) st_r <= S_HUNT;
        S_HUNT: if (!rxd) begin
          st_r <= S_START;
          cnt_r <= 4'h0;
        end
        S_START: if (tick16) begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `TICKS_HALF_BIT) begin
            st_r <= rxd ? S_HUNT : S_DATA;
            cnt_r <= 4'h0;
            idx_r <= 4'h0;
          end
        end
        S_DATA: if (tick16) begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `TICKS_PER_BIT) begin
            sh_r <= {rxd, sh_r[8:1]};
            idx_r <= idx_r + 4'h1;
            if (idx_r == total - 4'h1) st_r <= S_STOP;
          end
        end
        S_STOP: if (tick16) begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == `TICKS_PER_BIT) begin
            done <= 1'b1;
            data <= full[7:0] & dmask;
            // four-bit index: eight data bits put the a/d flag at bit 8
            ad <= ad_en & full[{2'h0, nbits} + 4'h5];
            ferr <= !rxd;
            brk <= !rxd && (full == 9'h000);
            st_r <= S_WAIT;
          end
        end
        default: st_r <= S_WAIT;
      endcase
    end
  end
end
endmodule // rx_char_shifter

// File: hdl/tx_char_shifter.v
`timescale 1ns/1ps
module tx_char_shifter (
  input wire mclk,
  input wire rstn,
  input wire tick16,
  input wire start,
  input wire [7:0] data,
  input wire ad,
  input wire ad_en,
  input wire [1:0] nbits,
  input wire two_stop,
  output reg txd,
  output wire busy
);
`include "uart_rx_wake_regs.vh"
reg [11:0] sh_r;
reg [3:0] left_r;
reg [3:0] cnt_r;
wire [7:0] dmask = 8'hFF >> (2'h3 - nbits);
wire [3:0] nd = {2'h0, nbits} + 4'h5;
// bit above the data stays clear so the a/d or stop bit alone sets it
wire [8:0] word = {1'b0, data & dmask} | ({8'h00, ad_en ? ad : 1'b1} << nd) | (9'h1FE << (nd + {3'h0, ad_en}));
assign busy = (left_r != 4'h0);
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    sh_r <= 12'hFFF;
    left_r <= 4'h0;
    cnt_r <= 4'h0;
    txd <= 1'b1;
  end else if (!busy) begin
    txd <= 1'b1;
    if (start) begin
      sh_r <= {2'h3, word, 1'b0};
      left_r <= 4'h2 + nd + {3'h0, ad_en} + {3'h0, two_stop};
      cnt_r <= 4'h0;
    end
  end else if (tick16) begin
    txd <= sh_r[0];
    cnt_r <= cnt_r + 4'h1;
    if (cnt_r == `TICKS_PER_BIT) begin
      sh_r <= {1'b1, sh_r[11:1]};
      left_r <= left_r - 4'h1;
    end
  end
end
endmodule // tx_char_shifter

// File: hdl/uart_rx_wake_regs.vh
// Functional notes
// - wake mode keeps receiver examining characters
// - parity field 11 selects wake mode
// - sub-mode 00: host commands only
// - tx frame: start, data, A/D, stops; wake mode with 5 to 7 data bits sends the first stop bit low
// - sub-mode 00, disabled: keep addresses only; enabled: all
// - A/D bit stored in parity status slot
// - framing, overrun, break always work
// - address-load bit decides address storing in sub-modes 01 to 11
// - sub-mode 01: own address enables receiver
// - sub-mode 10: foreign address disables receiver
// - sub-mode 11: wake and doze together
// - disable aborts character, queue kept
// - re-enable resumes at next start bit
// - receiver reset empties queue, clears ready
// - watchdog 64 bit times, restarts on read
// - command Ax enters, Cx leaves time-out
// - time-out mode ignores counter start/stop
// - transfer: halt one tick, reload, restart
// - counter end sets ready; mask gates bid
// - time-out enable clears ready, holds counter
// - leaving time-out clears counter ready
`ifndef UART_RX_WAKE_REGS_VH
`define UART_RX_WAKE_REGS_VH
// ----------------------------------------
// register word offsets (address bits 5:2)
// ----------------------------------------
`define OFS_MODE0 4'h0
`define OFS_MODE1 4'h1
`define OFS_MODE3 4'h2
`define OFS_STATUS 4'h3
`define OFS_CMD 4'h4
`define OFS_DATA 4'h5
`define OFS_ISR 4'h6
`define OFS_IMR 4'h7
`define OFS_WDEN 4'h8
`define OFS_COUNTER_PRESET_UPPER 4'h9
`define OFS_COUNTER_PRESET_LOWER 4'hA
`define OFS_STATION 4'hB
`define OFS_LINE 4'hC
// ----------------------------------------
// fields, commands, reset values, timing
// ----------------------------------------
`define MODE0_ADDR_LOAD 6
`define MODE1_AD_POL 2
`define WAKE_PARITY 2'h3
`define ISR_CT_READY 3
`define ISR_WATCHDOG 2
`define CMD_RX_ENABLE 2'h1
`define CMD_RX_DISABLE 2'h2
`define CMD_RX_RESET 4'h2
`define CMD_ERR_RESET 4'h4
`define CMD_CT_START 4'h8
`define CMD_CT_STOP 4'h9
`define CMD_TO_ON 4'hA
`define CMD_TO_OFF 4'hC
`define LINE_RESET 17'h00001
`define WD_BIT_TIMES 6'h3F
`define TICKS_PER_BIT 4'hF
`define TICKS_HALF_BIT 4'h7
`endif

// File: hdl/uart_rx_wakeup_timeout_ctrl.v
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module uart_rx_wakeup_timeout_ctrl (
  input wire mclk,
  input wire rstn,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire rxd_pin,
  output wire txd_pin,
  output wire counter_bid,
  output wire watchdog_bid
);
`include "uart_rx_wake_regs.vh"
// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] mode_register_zero_r;
reg [7:0] mode_register_one_r;
reg [7:0] mode_register_three_r;
reg [7:0] interrupt_mask_reg_r;
reg [7:0] watchdog_char_xon_enable_reg_r;
reg [7:0] counter_preset_upper_r;
reg [7:0] counter_preset_lower_r;
reg [7:0] station_addr_r;
reg [16:0] line_cfg_r;
reg rx_enabled_r;
reg overrun_r;
reg ct_ready_r;
reg wd_flag_r;
reg timeout_mode_r;
reg rd_ack_r;
reg rx_s1_r;
reg rx_s2_r;
reg rx_s3_r;
reg rxd_r;
reg [15:0] baud_cnt_r;
reg tick16_r;
reg [3:0] bit_cnt_r;
reg [5:0] wd_cnt_r;
reg [15:0] ct_cnt_r;
reg ct_run_r;
reg ct_reload_pend_r;
reg ct_restart_pend_r;
reg [10:0] queue_mem [0:255];
reg [8:0] wr_ptr_r;
reg [8:0] rd_ptr_r;
// ----------------------------------------
// decode and command strobes
// ----------------------------------------
wire [3:0] idx = address[5:2];
wire wr_go = write;
wire rd_go = read && !rd_ack_r;
wire cmd_wr = wr_go && (idx == `OFS_CMD);
wire [3:0] cmd_hi = writedata[7:4];
wire [1:0] cmd_lo = writedata[1:0];
wire cmd_rx_reset = cmd_wr && (cmd_hi == `CMD_RX_RESET);
wire cmd_rx_dis = cmd_wr && (cmd_lo == `CMD_RX_DISABLE);
wire cmd_rx_en = cmd_wr && (cmd_lo == `CMD_RX_ENABLE);
wire cmd_err_reset = cmd_wr && (cmd_hi == `CMD_ERR_RESET);
wire cmd_to_on = cmd_wr && (cmd_hi == `CMD_TO_ON);
wire cmd_to_off = cmd_wr && (cmd_hi == `CMD_TO_OFF);
wire cmd_ct_start = cmd_wr && (cmd_hi == `CMD_CT_START) && !timeout_mode_r;
wire cmd_ct_stop = cmd_wr && (cmd_hi == `CMD_CT_STOP) && !timeout_mode_r;
wire queue_rd = rd_go && (idx == `OFS_DATA);
wire tx_wr = wr_go && (idx == `OFS_DATA);
assign waitrequest = read && !rd_ack_r;
// ----------------------------------------
// mode decode
// ----------------------------------------
wire wake_mode = (mode_register_one_r[4:3] == `WAKE_PARITY);
wire auto_wake = mode_register_three_r[0];
wire auto_doze = mode_register_three_r[1];
wire addr_load = mode_register_zero_r[`MODE0_ADDR_LOAD];
// ----------------------------------------
// line input synchroniser and bit clock
// ----------------------------------------
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    rx_s1_r <= 1'b1;
    rx_s2_r <= 1'b1;
    rx_s3_r <= 1'b1;
    rxd_r <= 1'b1;
  end else begin
    rx_s1_r <= rxd_pin;
    rx_s2_r <= rx_s1_r;
    rx_s3_r <= rx_s2_r;
    if (rx_s2_r == rx_s3_r) rxd_r <= rx_s3_r;
  end
end
// sixteen ticks per bit; divisor 0 behaves as 1
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    baud_cnt_r <= 16'h0000;
    tick16_r <= 1'b0;
  end else if (baud_cnt_r + 16'h0001 >= line_cfg_r[15:0]) begin
    baud_cnt_r <= 16'h0000;
    tick16_r <= 1'b1;
  end else begin
    baud_cnt_r <= baud_cnt_r + 16'h0001;
    tick16_r <= 1'b0;
  end
end
// ----------------------------------------
// character assembly and transmit
// ----------------------------------------
wire ch_done;
wire [7:0] ch_data;
wire ch_ad;
wire ch_ferr;
wire ch_brk;
wire tx_busy;
// a disabled receiver still hunts in wake mode
wire rx_abort = cmd_rx_dis || cmd_rx_reset || !(rx_enabled_r || wake_mode);
rx_char_shifter u_rx (
  .mclk(mclk),
  .rstn(rstn),
  .tick16(tick16_r),
  .rxd(rxd_r),
  .abort(rx_abort),
  .nbits(mode_register_one_r[1:0]),
  .ad_en(wake_mode),
  .done(ch_done),
  .data(ch_data),
  .ad(ch_ad),
  .ferr(ch_ferr),
  .brk(ch_brk)
);
tx_char_shifter u_tx (
  .mclk(mclk),
  .rstn(rstn),
  .tick16(tick16_r),
  .start(tx_wr),
  .data(writedata[7:0]),
  .ad(mode_register_one_r[`MODE1_AD_POL]),
  .ad_en(wake_mode),
  .nbits(mode_register_one_r[1:0]),
  .two_stop(line_cfg_r[16]),
  .txd(txd_pin),
  .busy(tx_busy)
);
// ----------------------------------------
// wake-up address handling
// ----------------------------------------
wire is_addr = wake_mode && ch_ad;
wire own_addr = (ch_data == station_addr_r);
wire auto_any = auto_wake || auto_doze;
wire wake_hit = ch_done && is_addr && auto_wake && own_addr;
wire doze_hit = ch_done && is_addr && auto_doze && !own_addr;
reg keep_char;
always @* begin
  keep_char = 1'b0;
  if (!wake_mode) keep_char = rx_enabled_r;
  else if (!auto_any) keep_char = rx_enabled_r || ch_ad;
  else if (ch_ad) keep_char = addr_load;
  else keep_char = rx_enabled_r;
end
wire queue_full = (wr_ptr_r[8] != rd_ptr_r[8]) && (wr_ptr_r[7:0] == rd_ptr_r[7:0]);
wire queue_empty = (wr_ptr_r == rd_ptr_r);
wire want_store = ch_done && keep_char;
// character lost when the queue has no room
wire do_store = want_store && !queue_full && !cmd_rx_reset;
wire transfer = do_store;
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    rx_enabled_r <= 1'b0;
  end else if (cmd_rx_dis || doze_hit) begin
    rx_enabled_r <= 1'b0;
  end else if (cmd_rx_en || wake_hit) begin
    rx_enabled_r <= 1'b1;
  end
end
// ----------------------------------------
// receive queue
// ----------------------------------------
always @(posedge mclk) begin
  if (do_store) begin
    queue_mem[wr_ptr_r[7:0]] <= {ch_brk, ch_ferr, ch_ad, ch_data};
  end
end
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    wr_ptr_r <= 9'h000;
    rd_ptr_r <= 9'h000;
  end else if (cmd_rx_reset) begin
    rd_ptr_r <= wr_ptr_r;
  end else begin
    if (do_store) wr_ptr_r <= wr_ptr_r + 9'h001;
    if (queue_rd && !queue_empty) rd_ptr_r <= rd_ptr_r + 9'h001;
  end
end
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    overrun_r <= 1'b0;
  end else if (want_store && queue_full) begin
    overrun_r <= 1'b1;
  end else if (cmd_err_reset || cmd_rx_reset) begin
    overrun_r <= 1'b0;
  end
end
// empty queue shows no head status
wire [10:0] head = queue_empty ? 11'h000 : queue_mem[rd_ptr_r[7:0]];
// ----------------------------------------
// receive watchdog
// ----------------------------------------
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    bit_cnt_r <= 4'h0;
    wd_cnt_r <= 6'h00;
    wd_flag_r <= 1'b0;
  end else if (queue_rd) begin
    bit_cnt_r <= 4'h0;
    wd_cnt_r <= 6'h00;
    wd_flag_r <= 1'b0;
  end else if (tick16_r && !queue_empty && !wd_flag_r) begin
    bit_cnt_r <= bit_cnt_r + 4'h1;
    if (bit_cnt_r == `TICKS_PER_BIT) begin
      wd_cnt_r <= wd_cnt_r + 6'h01;
      if (wd_cnt_r == `WD_BIT_TIMES) wd_flag_r <= 1'b1;
    end
  end
end
assign watchdog_bid = wd_flag_r && watchdog_char_xon_enable_reg_r[0];
// ----------------------------------------
// counter and receive time-out
// ----------------------------------------
wire [15:0] preset = {counter_preset_upper_r, counter_preset_lower_r};
wire ct_end = tick16_r && ct_run_r && !ct_reload_pend_r && (ct_cnt_r <= 16'h0001);
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    timeout_mode_r <= 1'b0;
  end else if (cmd_to_on) begin
    timeout_mode_r <= 1'b1;
  end else if (cmd_to_off) begin
    timeout_mode_r <= 1'b0;
  end
end
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    ct_cnt_r <= 16'h0000;
    ct_run_r <= 1'b0;
    ct_reload_pend_r <= 1'b0;
    ct_restart_pend_r <= 1'b0;
  end else if (cmd_to_on || cmd_ct_stop) begin
    ct_run_r <= 1'b0;
    ct_reload_pend_r <= 1'b0;
    ct_restart_pend_r <= 1'b0;
  end else if (cmd_ct_start) begin
    ct_cnt_r <= preset;
    ct_run_r <= 1'b1;
  end else begin
    if (timeout_mode_r && transfer) ct_reload_pend_r <= 1'b1;
    if (tick16_r) begin
      if (ct_reload_pend_r) begin
        ct_run_r <= 1'b0;
        ct_cnt_r <= preset;
        ct_reload_pend_r <= timeout_mode_r && transfer;
        ct_restart_pend_r <= 1'b1;
      end else if (ct_restart_pend_r) begin
        ct_run_r <= 1'b1;
        ct_restart_pend_r <= 1'b0;
      end else if (ct_end) begin
        ct_run_r <= 1'b0;
        ct_cnt_r <= 16'h0000;
      end else if (ct_run_r) begin
        ct_cnt_r <= ct_cnt_r - 16'h0001;
      end
    end
  end
end
// end of count wins over a clearing command
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    ct_ready_r <= 1'b0;
  end else if (ct_end) begin
    ct_ready_r <= 1'b1;
  end else if (cmd_to_on || cmd_to_off || cmd_ct_stop) begin
    ct_ready_r <= 1'b0;
  end
end
assign counter_bid = ct_ready_r && interrupt_mask_reg_r[`ISR_CT_READY];
// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    mode_register_zero_r <= 8'h00;
    mode_register_one_r <= 8'h00;
    mode_register_three_r <= 8'h00;
    interrupt_mask_reg_r <= 8'h00;
    watchdog_char_xon_enable_reg_r <= 8'h00;
    counter_preset_upper_r <= 8'h00;
    counter_preset_lower_r <= 8'h00;
    station_addr_r <= 8'h00;
    line_cfg_r <= `LINE_RESET;
  end else if (wr_go) begin
    case (idx)
      `OFS_MODE0: mode_register_zero_r <= writedata[7:0];
      `OFS_MODE1: mode_register_one_r <= writedata[7:0];
      `OFS_MODE3: mode_register_three_r <= writedata[7:0];
      `OFS_IMR: interrupt_mask_reg_r <= writedata[7:0];
      `OFS_WDEN: watchdog_char_xon_enable_reg_r <= writedata[7:0];
      `OFS_COUNTER_PRESET_UPPER: counter_preset_upper_r <= writedata[7:0];
      `OFS_COUNTER_PRESET_LOWER: counter_preset_lower_r <= writedata[7:0];
      `OFS_STATION: station_addr_r <= writedata[7:0];
      `OFS_LINE: line_cfg_r <= writedata[16:0];
      default: line_cfg_r <= line_cfg_r;
    endcase
  end
end
// ----------------------------------------
// register reads, one wait state
// ----------------------------------------
wire [7:0] status = {head[10:8], overrun_r, !tx_busy, !tx_busy, queue_full, !queue_empty};
wire [7:0] interrupt_status_reg = {4'h0, ct_ready_r, wd_flag_r, 2'h0};
reg [31:0] rd_mux;
always @* begin
  case (idx)
    `OFS_MODE0: rd_mux = {24'h000000, mode_register_zero_r};
    `OFS_MODE1: rd_mux = {24'h000000, mode_register_one_r};
    `OFS_MODE3: rd_mux = {24'h000000, mode_register_three_r};
    `OFS_STATUS: rd_mux = {24'h000000, status};
    `OFS_DATA: rd_mux = {24'h000000, head[7:0]};
    `OFS_ISR: rd_mux = {24'h000000, interrupt_status_reg};
    `OFS_IMR: rd_mux = {24'h000000, interrupt_mask_reg_r};
    `OFS_WDEN: rd_mux = {24'h000000, watchdog_char_xon_enable_reg_r};
    `OFS_COUNTER_PRESET_UPPER: rd_mux = {24'h000000, counter_preset_upper_r};
    `OFS_COUNTER_PRESET_LOWER: rd_mux = {24'h000000, counter_preset_lower_r};
    `OFS_STATION: rd_mux = {24'h000000, station_addr_r};
    `OFS_LINE: rd_mux = {15'h0000, line_cfg_r};
    default: rd_mux = 32'h00000000;
  endcase
end
always @(posedge mclk or negedge rstn) begin
  if (!rstn) begin
    rd_ack_r <= 1'b0;
    readdata <= 32'h00000000;
  end else begin
    rd_ack_r <= rd_go;
    if (rd_go) readdata <= rd_mux;
  end
end
endmodule // uart_rx_wakeup_timeout_ctrl

// File: verif/line_station.sv
`timescale 1ns/1ps
module line_station #(
  parameter int BIT = 16
) (
  input wire mclk,
  input wire txd,
  output logic rxd
);
  // ----------------------------------------
  // master station on the shared line
  // ----------------------------------------
  initial rxd = 1'b1;
  // frame: start, data lsb first, a/d only in wake mode, one stop
  task automatic send(input logic [7:0] d, input logic ad, input bit wk, input logic sb);
    logic [10:0] f;
    int n;
    f = {sb, ad, d, 1'b0};
    n = wk ? 11 : 10;
    if (!wk) f[9] = sb;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rxd <= f[i];
      repeat (BIT - 1) @(posedge mclk);
    end
    @(posedge mclk);
    // pulled up between frames
    rxd <= 1'b1;
  endtask
  // sampled mid-bit, so edge order of txd does not matter
  task automatic recv(output logic [7:0] d, output logic ad);
    @(negedge txd);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge mclk);
      if (i < 8) d[i] = txd;
      else ad = txd;
    end
    // run past the stop bit, so the transmitter is idle before the next write
    repeat (2 * BIT) @(posedge mclk);
  endtask
endmodule // line_station

// File: verif/tb_uart_rx_wakeup_timeout_ctrl.sv
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("[ERR] %0t %h %h", $time, g, e); end end
module tb_uart_rx_wakeup_timeout_ctrl;
  logic mclk, rstn, read, write;
  logic [5:0] address;
  logic [31:0] writedata, q;
  wire [31:0] readdata;
  wire waitrequest, rxd_pin, txd_pin, counter_bid, watchdog_bid;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int en, st;
  int mq[$];
  logic [7:0] td;
  logic ta;
  uart_rx_wakeup_timeout_ctrl i_dut (.mclk(mclk), .rstn(rstn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .counter_bid(counter_bid), .watchdog_bid(watchdog_bid));
  line_station i_line (.mclk(mclk), .txd(txd_pin), .rxd(rxd_pin));
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // bus, line and model tasks
  // ----------------------------------------
  task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // waitrequest read here still holds its value from before this edge
    do @(posedge mclk); while (waitrequest);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rx(input logic [7:0] d, input logic ad, input bit wk, input int s, input int l,
    input logic sb = 1'b1);
    bit k;
    i_line.send(d, ad, wk, sb);
    k = (en != 0);
    if (wk && ad) begin
      if (s[0] && d == st) en = 1;
      if (s[1] && d != st) en = 0;
      k = (s == 0) || (l != 0);
    end
    if (k) mq.push_back(int'({!sb, wk & ad, d}));
  endtask
  task automatic drain();
    int e;
    while (mq.size() > 0) begin
      e = mq.pop_front();
      bus(6'h0C, 1'b0, 32'h0);
      `CHK({q[7:5], q[0]}, {1'b0, e[9:8], 1'b1})
      bus(6'h14, 1'b0, 32'h0);
      `CHK(q[7:0], e[7:0])
    end
    bus(6'h0C, 1'b0, 32'h0);
    `CHK({q[7:5], q[0]}, 4'h0)
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 6'h00;
    writedata = 32'h0;
    void'($urandom(32'hC6DE));
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    bus(6'h30, 1'b0, 32'h0);
    `CHK(q, 32'h00001)
    bus(6'h3C, 1'b1, 32'hFF);
    bus(6'h3C, 1'b0, 32'h0);
    `CHK(q, 32'h0)
    bus(6'h04, 1'b1, 32'h3);
    bus(6'h10, 1'b1, 32'h01);
    en = 1;
    rx(8'($urandom), 1'b0, 0, 0, 0);
    // disable lands mid-frame
    fork
      i_line.send(8'hA5, 1'b0, 0, 1'b1);
      begin
        tick(60);
        bus(6'h10, 1'b1, 32'h02);
      end
    join
    bus(6'h10, 1'b1, 32'h01);
    rx(8'($urandom), 1'b0, 0, 0, 0);
    drain();
    rx(8'h11, 1'b0, 0, 0, 0);
    rx(8'h22, 1'b0, 0, 0, 0);
    bus(6'h10, 1'b1, 32'h20);
    mq.delete();
    drain();
    st = 8'($urandom);
    bus(6'h2C, 1'b1, 32'(st));
    bus(6'h04, 1'b1, 32'h1B);
    for (int s = 0; s < 4; s++) begin
      for (int l = 0; l < 2; l++) begin
        bus(6'h08, 1'b1, 32'(s));
        bus(6'h00, 1'b1, 32'(l << 6));
        bus(6'h10, 1'b1, 32'h02);
        en = 0;
        rx(8'(st ^ 1), 1'b1, 1, s, l);
        rx(8'($urandom), 1'b0, 1, s, l);
        rx(8'(st), 1'b1, 1, s, l);
        if (s == 0) begin
          // host saw its own address, so it opens the receiver
          bus(6'h10, 1'b1, 32'h01);
          en = 1;
        end
        rx(8'($urandom), 1'b0, 1, s, l);
        rx(8'(st ^ 2), 1'b1, 1, s, l);
        rx(8'($urandom), 1'b0, 1, s, l);
        drain();
      end
    end
    bus(6'h08, 1'b1, 32'h0);
    bus(6'h10, 1'b1, 32'h02);
    en = 0;
    rx(8'h5A, 1'b1, 1, 0, 0, 1'b0);
    drain();
    for (int p = 0; p < 2; p++) begin
      bus(6'h04, 1'b1, 32'h1B | 32'(p << 2));
      fork
        bus(6'h14, 1'b1, 32'h3C + 32'(p));
        i_line.recv(td, ta);
      join
      `CHK(td, 8'(8'h3C + p))
      `CHK(ta, 1'(p))
    end
    bus(6'h04, 1'b1, 32'h3);
    bus(6'h10, 1'b1, 32'h01);
    en = 1;
    bus(6'h20, 1'b1, 32'h1);
    rx(8'($urandom), 1'b0, 0, 0, 0);
    tick(900);
    `CHK(watchdog_bid, 1'b0)
    tick(300);
    `CHK(watchdog_bid, 1'b1)
    drain();
    `CHK(watchdog_bid, 1'b0)
    bus(6'h1C, 1'b1, 32'h8);
    bus(6'h24, 1'b1, 32'h0);
    // just over one 160-clock character
    bus(6'h28, 1'b1, 32'hC0);
    bus(6'h10, 1'b1, 32'hA0);
    bus(6'h10, 1'b1, 32'h80);
    tick(300);
    `CHK(counter_bid, 1'b0)
    rx(8'($urandom), 1'b0, 0, 0, 0);
    rx(8'($urandom), 1'b0, 0, 0, 0);
    tick(100);
    `CHK(counter_bid, 1'b0)
    tick(150);
    `CHK(counter_bid, 1'b1)
    bus(6'h1C, 1'b1, 32'h0);
    bus(6'h18, 1'b0, 32'h0);
    `CHK({q[3], counter_bid}, 2'b10)
    bus(6'h1C, 1'b1, 32'h8);
    bus(6'h10, 1'b1, 32'hA0);
    tick(1);
    `CHK(counter_bid, 1'b0)
    rx(8'($urandom), 1'b0, 0, 0, 0);
    tick(250);
    `CHK(counter_bid, 1'b1)
    bus(6'h10, 1'b1, 32'hC0);
    tick(1);
    `CHK(counter_bid, 1'b0)
    drain();
    give_verdict();
  end
endmodule // tb_uart_rx_wakeup_timeout_ctrl
bind uart_rx_wakeup_timeout_ctrl uart_rx_wakeup_timeout_ctrl_checker i_chk (.mclk(mclk), .rstn(rstn),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .counter_bid(counter_bid),
  .watchdog_bid(watchdog_bid));

// File: verif/uart_rx_wakeup_timeout_ctrl_asserts.sv
`timescale 1ns/1ps
module uart_rx_wakeup_timeout_ctrl_checker (
  input wire mclk,
  input wire rstn,
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire rxd_pin,
  input wire txd_pin,
  input wire counter_bid,
  input wire watchdog_bid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // cycles since last queue read
  // ----------------------------------------
  // a lower bound only: the watchdog also waits while the queue is empty
  int unsigned idle_r;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) idle_r <= 0;
    else if (read && !waitrequest && address[5:2] == 4'h5) idle_r <= 0;
    else if (idle_r < 100000) idle_r <= idle_r + 1;
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  wr_no_wait_a: assert property (write |-> !waitrequest) else $error("write stalled");
  rd_wait_once_a: assert property (read && waitrequest |=> !read || !waitrequest)
    else $error("read stalled twice");
  rd_rewait_a: assert property (read && !waitrequest |=> !read || waitrequest)
    else $error("read answered without wait");
  wd_min_time_a: assert property ($rose(watchdog_bid) |-> idle_r >= 1008)
    else $error("watchdog early");
  wd_read_clr_a: assert property (read && !waitrequest && address[5:2] == 4'h5 |=> !watchdog_bid)
    else $error("watchdog kept after read");
  wd_mask_a: assert property (write && address[5:2] == 4'h8 && !writedata[0] |=> !watchdog_bid)
    else $error("watchdog bid unmasked");
  ctr_mask_a: assert property (write && address[5:2] == 4'h7 && !writedata[3] |=> !counter_bid)
    else $error("counter bid unmasked");
  to_on_clr_a: assert property (write && address[5:2] == 4'h4 && writedata[7:4] == 4'hA && counter_bid
    |=> !counter_bid) else $error("time-out entry kept ready");
  to_off_clr_a: assert property (write && address[5:2] == 4'h4 && writedata[7:4] == 4'hC && counter_bid
    |=> !counter_bid) else $error("time-out exit kept ready");
  tx_low_len_a: assert property ($fell(txd_pin) |-> (!txd_pin) [*8] ##1 (!txd_pin) [*8])
    else $error("short low bit");
endmodule // uart_rx_wakeup_timeout_ctrl_checker
